// >>> hdl/spa_alu_slice.sv
// arithmetic slice: shift, six operations, carry, overflow limiting
// assumes the sequencer presents an instruction with both operands at the
// take phase and writes back wr_data_o when wr_en_o is high
`timescale 1ns/1ps
// Summary of operation
// [RQ1] every instruction occupies four clocks and 192 slots form a 768-clock sample period; a write-back with program end set ends the period early.
// [RQ2] right shifts of the source refill the top with copies of its sign bit.
// [RQ3] left shifts of the source fill vacated low bits with zero.
// [RQ4] the zero shift code passes the source through unchanged.
// [RQ5] a load of location 0 into location 0 with no shift clears the carry flag.
// [RQ6] sources may be any of 64 locations, destinations only the accumulator or scratch up to 40; wr_addr_o takes any of the 64 from dst_addr_i.
// [RQ7] absolute-add adds the magnitude of the shifted source to the destination with carry and overflow.
// [RQ8] a conditional absolute-add turns limiting off, a conditional exclusive-or or program end turns it on.
// [RQ9] magnitude writes the shifted source if non-negative, otherwise its two's-complement negation.
// [RQ10] magnitude never carries, clears the carry flag and ignores conditions.
// [RQ11] add stores source plus destination, and leaves the destination when the tested bit is zero.
// [RQ12] and stores the bitwise conjunction and ignores conditions.
// [RQ13] a condition tests either the accumulator sign bit or one bit, bit zero the lowest.
// [RQ14] a failed conditional add adds zero, keeping the destination and clearing the carry.
// [RQ15] with limiting on, an overflowing result becomes the largest positive or most negative value.
module spa_alu_slice #(
    parameter int W     = 24,
    parameter int ACC_W = 8
) (
    input  wire logic               ref_clk_i,
    input  wire logic               resetn_i,
    input  wire logic               instr_valid_i,
    input  wire spa_pkg::spa_op_t   opcode_i,
    input  wire logic [5:0]         dst_addr_i,
    input  wire logic [5:0]         src_addr_i,
    input  wire logic [3:0]         shift_code_i,
    input  wire logic               cond_en_i,
    input  wire logic [3:0]         cond_sel_i,
    input  wire logic               prog_end_i,
    input  wire logic [W-1:0]       src_data_i,
    input  wire logic [W-1:0]       dst_data_i,
    input  wire logic [ACC_W-1:0]   digit_accumulator_register_i,
    output logic                    slot_start_o,
    output logic                    wr_en_o,
    output logic [5:0]              wr_addr_o,
    output logic [W-1:0]            wr_data_o,
    output logic                    carry_o,
    output logic                    overflow_o,
    output logic                    limit_en_o,
    output logic                    period_end_o
);
    localparam logic [W-1:0] MAX_POS = {1'b0, {(W-1){1'b1}}};
    localparam logic [W-1:0] MAX_NEG = {1'b1, {(W-1){1'b0}}};
    initial
    begin
        if (ACC_W != 8) $error("condition select serves an 8-bit accumulator only");
    end
    // ****************************************************
    // slot phase and instruction registers
    // ****************************************************
    spa_pkg::spa_phase_t phase;
    spa_pkg::spa_phase_t next_phase;
    spa_pkg::spa_op_t    op_q;
    logic                busy;
    logic [5:0]          dst_q;
    logic [5:0]          src_q;
    logic [3:0]          shift_q;
    logic                cond_q;
    logic                pass_q;
    logic                fin_q;
    logic [W-1:0]        dst_d;
    logic [W-1:0]        src_d;
    logic [W-1:0]        sh_q;
    logic [7:0]          slot;
    spa_shift_if #(.W(W)) shx ();
    spa_shifter #(.W(W)) u_shift (.sh(shx));
    assign shx.operand = src_d;
    assign shx.code    = shift_q;
    always_comb
    begin
        case (phase)
            spa_pkg::SPA_PH_TAKE:  next_phase = spa_pkg::SPA_PH_SHIFT;
            spa_pkg::SPA_PH_SHIFT: next_phase = spa_pkg::SPA_PH_EXEC;
            spa_pkg::SPA_PH_EXEC:  next_phase = spa_pkg::SPA_PH_WRITE;
            spa_pkg::SPA_PH_WRITE: next_phase = spa_pkg::SPA_PH_TAKE;
            default:               next_phase = spa_pkg::SPA_PH_TAKE;
        endcase
    end

    always_ff @(posedge ref_clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
            phase <= spa_pkg::SPA_PH_TAKE;
        else
            phase <= next_phase;                            // see [RQ1]
    end

    assign slot_start_o = (phase == spa_pkg::SPA_PH_TAKE);
    assign wr_en_o      = busy && (phase == spa_pkg::SPA_PH_WRITE);
    assign wr_addr_o    = dst_q;                            // see [RQ6]
    always_ff @(posedge ref_clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            busy    <= 1'b0;
            op_q    <= spa_pkg::SPA_OP_LOAD;
            dst_q   <= spa_pkg::ADDR_ZERO;
            src_q   <= spa_pkg::ADDR_ZERO;
            shift_q <= spa_pkg::SHIFT_NONE;
            cond_q  <= 1'b0;
            pass_q  <= 1'b1;
            fin_q   <= 1'b0;
            dst_d   <= '0;
            src_d   <= '0;
        end
        else if (slot_start_o)
        begin
            busy    <= instr_valid_i;
            op_q    <= opcode_i;
            dst_q   <= dst_addr_i;
            src_q   <= src_addr_i;
            shift_q <= shift_code_i;
            cond_q  <= cond_en_i;
            fin_q   <= prog_end_i;
            dst_d   <= dst_data_i;
            src_d   <= src_data_i;
            // sign or one accumulator bit, bit zero lowest
            pass_q  <= !cond_en_i || ((cond_sel_i == spa_pkg::COND_SIGN)
                                      ? digit_accumulator_register_i[ACC_W-1]
                                      : digit_accumulator_register_i[cond_sel_i[2:0]]); // see [RQ13]
        end
    end
    always_ff @(posedge ref_clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
            sh_q <= '0;
        else if (phase == spa_pkg::SPA_PH_SHIFT)
            sh_q <= shx.result;                             // see [RQ2] [RQ3] [RQ4]
    end

    // ****************************************************
    // execute
    // ****************************************************
    logic [W-1:0] mag;
    logic [W-1:0] addend;
    logic [W:0]   sum;
    logic [W-1:0] next_res;
    logic         next_carry;
    logic         next_ovf;
    logic         ovf_neg;
    logic         carry_q;
    always_comb
    begin
        mag        = sh_q[W-1] ? W'(~sh_q + 1'b1) : sh_q;   // see [RQ9]
        addend     = (op_q == spa_pkg::SPA_OP_ABSADD) ? mag : (pass_q ? sh_q : '0); // see [RQ7] [RQ14]
        sum        = {1'b0, dst_d} + {1'b0, addend};
        next_res   = sum[W-1:0];
        next_carry = 1'b0;
        next_ovf   = 1'b0;
        ovf_neg    = 1'b0;
        case (op_q)
            spa_pkg::SPA_OP_ABSADD, spa_pkg::SPA_OP_ADD:
            begin
                next_carry = sum[W];                        // see [RQ7] [RQ11]
                next_ovf   = (dst_d[W-1] == addend[W-1]) && (sum[W-1] != dst_d[W-1]);
                ovf_neg    = dst_d[W-1];
            end
            spa_pkg::SPA_OP_MAG:
            begin
                next_res   = mag;                           // see [RQ9] [RQ10]
                next_ovf   = sh_q[W-1] && mag[W-1];
            end
            spa_pkg::SPA_OP_AND: next_res = sh_q & dst_d;   // see [RQ12]
            spa_pkg::SPA_OP_XOR: next_res = sh_q ^ dst_d;
            spa_pkg::SPA_OP_LOAD: next_res = pass_q ? sh_q : dst_d; // see [RQ5]
            default: next_res = dst_d;
        endcase
        // saturation hides wraparound; off when software wants modular sums
        if (next_ovf && limit_en_o)
            next_res = ovf_neg ? MAX_NEG : MAX_POS;         // see [RQ15]
    end

    always_ff @(posedge ref_clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            wr_data_o  <= '0;
            carry_q    <= 1'b0;
            overflow_o <= 1'b0;
        end
        else if (phase == spa_pkg::SPA_PH_EXEC)
        begin
            wr_data_o  <= next_res;
            carry_q    <= next_carry;
            overflow_o <= next_ovf;
        end
    end
    // ****************************************************
    // flags and sample period
    // ****************************************************
    always_ff @(posedge ref_clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
            carry_o <= 1'b0;
        else if (wr_en_o)
            carry_o <= carry_q;                             // see [RQ5] [RQ10] [RQ14]
    end

    always_ff @(posedge ref_clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
            limit_en_o <= 1'b1;
        else if (wr_en_o && (fin_q || (cond_q && op_q == spa_pkg::SPA_OP_XOR)))
            limit_en_o <= 1'b1;                             // see [RQ8]
        else if (wr_en_o && cond_q && op_q == spa_pkg::SPA_OP_ABSADD)
            limit_en_o <= 1'b0;                             // see [RQ8]
    end

    always_ff @(posedge ref_clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            slot         <= '0;
            period_end_o <= 1'b0;
        end
        else
        begin
            period_end_o <= 1'b0;
            if (phase == spa_pkg::SPA_PH_WRITE)
            begin
                if ((slot == spa_pkg::SLOT_LAST) || (wr_en_o && fin_q))
                begin
                    slot         <= '0;                     // see [RQ1]
                    period_end_o <= 1'b1;
                end
                else
                    slot <= 8'(slot + 8'h01);
            end
        end
    end

    // ****************************************************
    // assertions
    // ****************************************************
    logic [11:0] cyc;
    logic        early_end;
    always_ff @(posedge ref_clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            cyc       <= '0;
            early_end <= 1'b0;
        end
        else
        begin
            cyc       <= period_end_o ? 12'h001 : 12'(cyc + 12'h001);
            early_end <= (phase == spa_pkg::SPA_PH_WRITE) && wr_en_o && fin_q;
        end
    end

    chk_slot_length: assert property (@(posedge ref_clk_i) disable iff (!resetn_i) // see [RQ1]
        slot_start_o && instr_valid_i |-> !wr_en_o ##3 wr_en_o ##1 slot_start_o)
        else $error("instruction slot not four clocks");
    chk_period_span: assert property (@(posedge ref_clk_i) disable iff (!resetn_i) // see [RQ1]
        period_end_o && !early_end && $past(slot) == spa_pkg::SLOT_LAST && cyc > 12'h001 |-> cyc == 12'(spa_pkg::PERIOD_CYCLES))
        else $error("sample period length wrong");
    chk_right_fill: assert property (@(posedge ref_clk_i) disable iff (!resetn_i) // see [RQ2]
        shx.code <= spa_pkg::SHIFT_R_MAX |-> shx.result[W-1] == shx.operand[W-1])
        else $error("right shift lost sign fill");
    chk_left_fill: assert property (@(posedge ref_clk_i) disable iff (!resetn_i) // see [RQ3]
        shx.code == spa_pkg::SHIFT_L2 |-> shx.result[1:0] == 2'b00 && shx.result[W-1:2] == shx.operand[W-3:0])
        else $error("left shift fill wrong");
    chk_zero_shift: assert property (@(posedge ref_clk_i) disable iff (!resetn_i) // see [RQ4]
        shx.code == spa_pkg::SHIFT_NONE |-> shx.result == shx.operand)
        else $error("zero shift altered operand");
    chk_nop_carry: assert property (@(posedge ref_clk_i) disable iff (!resetn_i) // see [RQ5]
        wr_en_o && op_q == spa_pkg::SPA_OP_LOAD && dst_q == spa_pkg::ADDR_ZERO && src_q == spa_pkg::ADDR_ZERO
        && shift_q == spa_pkg::SHIFT_NONE |-> wr_data_o == dst_d ##1 !carry_o)
        else $error("load left carry set");
    chk_absadd_sum: assert property (@(posedge ref_clk_i) disable iff (!resetn_i) // see [RQ7]
        wr_en_o && op_q == spa_pkg::SPA_OP_ABSADD && !overflow_o
        |-> wr_data_o == W'(dst_d + (sh_q[W-1] ? W'(~sh_q + 1'b1) : sh_q)))
        else $error("absolute add result wrong");
    chk_limit_off: assert property (@(posedge ref_clk_i) disable iff (!resetn_i) // see [RQ8]
        wr_en_o && cond_q && !fin_q && op_q == spa_pkg::SPA_OP_ABSADD |=> !limit_en_o [*4])
        else $error("limiting not disabled");
    chk_mag_sign: assert property (@(posedge ref_clk_i) disable iff (!resetn_i) // see [RQ9]
        wr_en_o && op_q == spa_pkg::SPA_OP_MAG && !overflow_o |-> !wr_data_o[W-1])
        else $error("magnitude negative");
    chk_mag_carry: assert property (@(posedge ref_clk_i) disable iff (!resetn_i) // see [RQ10]
        wr_en_o && op_q == spa_pkg::SPA_OP_MAG |=> !carry_o)
        else $error("magnitude set carry");
    chk_cond_hold: assert property (@(posedge ref_clk_i) disable iff (!resetn_i) // see [RQ11] [RQ14]
        wr_en_o && op_q == spa_pkg::SPA_OP_ADD && !pass_q |-> wr_data_o == dst_d ##1 !carry_o)
        else $error("failed condition changed destination");
    chk_and_value: assert property (@(posedge ref_clk_i) disable iff (!resetn_i) // see [RQ12]
        wr_en_o && op_q == spa_pkg::SPA_OP_AND |-> wr_data_o == (sh_q & dst_d) && !carry_q)
        else $error("and result wrong");
    chk_saturate: assert property (@(posedge ref_clk_i) disable iff (!resetn_i) // see [RQ15]
        wr_en_o && overflow_o && $past(limit_en_o, 2) && limit_en_o |-> wr_data_o == MAX_POS || wr_data_o == MAX_NEG)
        else $error("overflow not limited");
endmodule // spa_alu_slice

// >>> hdl/spa_pkg.sv
// constants and types of the signal processor arithmetic slice
// assumes one system clock; operand memory and sequencer sit outside
package spa_pkg;

    // ****************************************************
    // timing
    // ****************************************************
    localparam int unsigned SLOT_CYCLES   = 4;
    localparam int unsigned PROG_SLOTS    = 192;
    localparam int unsigned PERIOD_CYCLES = SLOT_CYCLES * PROG_SLOTS;
    localparam logic [7:0]  SLOT_LAST     = 8'(PROG_SLOTS - 1);

    // ****************************************************
    // shift codes: 0..13 right, then two left codes
    // ****************************************************
    localparam logic [3:0] SHIFT_NONE  = 4'h0;
    localparam logic [3:0] SHIFT_R_MAX = 4'hD;
    localparam logic [3:0] SHIFT_L1    = 4'hE;
    localparam logic [3:0] SHIFT_L2    = 4'hF;

    // ****************************************************
    // conditional select: 0..7 bit of accumulator, 8 sign
    // ****************************************************
    localparam logic [3:0] COND_SIGN   = 4'h8;
    localparam logic [5:0] ADDR_ZERO   = 6'h00;

    typedef enum logic [2:0] {
        SPA_OP_ABSADD = 3'h0,
        SPA_OP_MAG    = 3'h1,
        SPA_OP_ADD    = 3'h2,
        SPA_OP_AND    = 3'h3,
        SPA_OP_LOAD   = 3'h4,
        SPA_OP_XOR    = 3'h5
    } spa_op_t;

    typedef enum logic [1:0] {
        SPA_PH_TAKE  = 2'h0,
        SPA_PH_SHIFT = 2'h1,
        SPA_PH_EXEC  = 2'h3,
        SPA_PH_WRITE = 2'h2
    } spa_phase_t;

endpackage

// >>> hdl/spa_shift_if.sv
// carrier between the slice core and its source shifter
// assumes both ends share one word width
`timescale 1ns/1ps
interface spa_shift_if #(parameter int W = 24);
    logic [W-1:0] operand;
    logic [3:0]   code;
    logic [W-1:0] result;
    modport core    (output operand, output code, input result);
    modport shifter (input operand, input code, output result);
endinterface

// >>> hdl/spa_shifter.sv
// source shifter: arithmetic right by 0..13, left by one or two
// assumes a purely combinational path inside one slot phase
`timescale 1ns/1ps
module spa_shifter #(
    parameter int W = 24
) (
    spa_shift_if.shifter sh
);
    // ****************************************************
    // checks
    // ****************************************************
    initial
    begin
        if (W < 16) $error("word too narrow for the shift range");
    end

    always_comb
    begin
        if (sh.code == spa_pkg::SHIFT_L1)
            sh.result = {sh.operand[W-2:0], 1'b0};          // see [RQ3]
        else if (sh.code == spa_pkg::SHIFT_L2)
            sh.result = {sh.operand[W-3:0], 2'b00};         // see [RQ3]
        else
            sh.result = W'($signed(sh.operand) >>> sh.code); // see [RQ2] [RQ4]
    end
endmodule // spa_shifter

// >>> bench/spa_opmem_model.sv
// operand memory partner: 64 words, read at once, written on the strobe
// assumes the bench preloads words through put before each instruction
`timescale 1ns/1ps
module spa_opmem_model #(
    parameter int W = 24
) (
    input  wire logic         ref_clk_i,
    input  wire logic [5:0]   src_addr_i,
    input  wire logic [5:0]   dst_addr_i,
    input  wire logic         wr_en_i,
    input  wire logic [5:0]   wr_addr_i,
    input  wire logic [W-1:0] wr_data_i,
    output logic      [W-1:0] src_data_o,
    output logic      [W-1:0] dst_data_o
);
    // any of 64 places may be read as a source
    logic [W-1:0] mem [64];

    assign src_data_o = mem[src_addr_i];
    assign dst_data_o = mem[dst_addr_i];

    // write-back lands on the edge that ends the strobe cycle
    always @(posedge ref_clk_i)
    begin
        if (wr_en_i === 1'h1)
        begin
            mem[wr_addr_i] <= wr_data_i;
        end
    end

    task automatic put(input logic [5:0] a, input logic [W-1:0] v);
        mem[a] = v;
    endtask
endmodule // spa_opmem_model

// >>> bench/spa_alu_slice_tb_top.sv
// bench top: timing, then table of instructions, then carry, limiting and reset cases
// assumes operands come from spa_opmem_model at places 50 and 7, the no-op from place 0 into place 0
`timescale 1ns/1ps
module spa_alu_slice_tb_top;
    typedef struct packed {
        logic [2:0]  op;
        logic [3:0]  sh;
        logic        ce;
        logic [3:0]  cs;
        logic [7:0]  dv;
        logic [23:0] src;
        logic [23:0] dst;
        logic [23:0] res;
        logic        cy;
        logic        ov;
    } spa_row_t;

    // **********
    // rows: op sh cond sel acc src dst result carry overflow
    // **********
    spa_row_t rows [14] = '{
        {3'h2,4'h0,1'h0,4'h0,8'h00,24'h000010,24'h000020,24'h000030,1'h0,1'h0},
        {3'h2,4'h1,1'h0,4'h0,8'h00,24'h800000,24'h400000,24'h000000,1'h1,1'h0},
        {3'h3,4'hF,1'h1,4'h0,8'h00,24'h1FFFFF,24'h0000FF,24'h0000FC,1'h0,1'h0},
        {3'h2,4'hE,1'h0,4'h0,8'h00,24'h000003,24'h000001,24'h000007,1'h0,1'h0},
        {3'h2,4'hD,1'h0,4'h0,8'h00,24'h800000,24'h000400,24'h000000,1'h1,1'h0},
        {3'h1,4'h0,1'h1,4'h2,8'h00,24'hFFFFFF,24'h000000,24'h000001,1'h0,1'h0},
        {3'h1,4'h2,1'h0,4'h0,8'h00,24'h000123,24'h000000,24'h000048,1'h0,1'h0},
        {3'h0,4'h0,1'h0,4'h0,8'h00,24'hFFFFF0,24'h000005,24'h000015,1'h0,1'h0},
        {3'h0,4'h0,1'h0,4'h0,8'h00,24'h000001,24'hFFFFFF,24'h000000,1'h1,1'h0},
        {3'h2,4'h0,1'h1,4'h3,8'hF7,24'h000002,24'h000003,24'h000003,1'h0,1'h0},
        {3'h2,4'h0,1'h1,4'h3,8'h08,24'h000002,24'h000003,24'h000005,1'h0,1'h0},
        {3'h2,4'h0,1'h1,4'h8,8'h80,24'hFFFFFF,24'h000003,24'h000002,1'h1,1'h0},
        {3'h2,4'h0,1'h1,4'h8,8'h7F,24'h000004,24'h000003,24'h000003,1'h0,1'h0},
        {3'h2,4'h0,1'h0,4'h0,8'h00,24'h7FFFFF,24'h000001,24'h7FFFFF,1'h0,1'h1}};

    logic              ref_clk_i = 1'h0;
    logic              resetn_i = 1'h0;
    logic              instr_valid_i = 1'h0;
    spa_pkg::spa_op_t  opcode_i = spa_pkg::SPA_OP_ADD;
    logic [5:0]        dst_addr_i = 6'h00;
    logic [5:0]        src_addr_i = 6'h00;
    logic [3:0]        shift_code_i = 4'h0;
    logic              cond_en_i = 1'h0;
    logic [3:0]        cond_sel_i = 4'h0;
    logic              prog_end_i = 1'h0;
    logic [7:0]        digit_accumulator_register_i = 8'h00;
    logic [23:0]       src_data_i, dst_data_i, wr_data_o;
    logic [5:0]        wr_addr_o;
    logic              slot_start_o, wr_en_o, carry_o, overflow_o, limit_en_o, period_end_o;
    int                n_mismatch = 0;
    int                checks = 0;
    int                cycles = 0;
    int                n, k;
    spa_row_t          r;

    spa_alu_slice #(.W(24), .ACC_W(8)) i_dut (.ref_clk_i, .resetn_i, .instr_valid_i, .opcode_i,
        .dst_addr_i, .src_addr_i, .shift_code_i, .cond_en_i, .cond_sel_i, .prog_end_i, .src_data_i,
        .dst_data_i, .digit_accumulator_register_i, .slot_start_o, .wr_en_o, .wr_addr_o, .wr_data_o, .carry_o,
        .overflow_o, .limit_en_o, .period_end_o);

    spa_opmem_model #(.W(24)) i_mem (.ref_clk_i, .src_addr_i, .dst_addr_i, .wr_en_i(wr_en_o),
        .wr_addr_i(wr_addr_o), .wr_data_i(wr_data_o), .src_data_o(src_data_i), .dst_data_o(dst_data_i));

    always #2 ref_clk_i = ~ref_clk_i;

    // hang guard: the whole run is near 1650 cycles
    always @(posedge ref_clk_i)
    begin
        cycles++;
        if (cycles == 8000)
        begin
            n_mismatch++;
            test_done();
        end
    end

    task automatic test_done();
        $display("checks %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0)
        begin
            $display("== PASSED ==");
        end
        else
        begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic tick();
        @(posedge ref_clk_i);
        #1;
    endtask

    task automatic chk_rst();
        chk("reset take phase", slot_start_o, 1'h1);
        chk("reset strobe", wr_en_o, 1'h0);
        chk("reset data", wr_data_o, 24'h000000);
        chk("reset carry", carry_o, 1'h0);
        chk("reset overflow", overflow_o, 1'h0);
        chk("reset limiting", limit_en_o, 1'h1);
        chk("reset period end", period_end_o, 1'h0);
    endtask

    // one slot: present at take phase, strobe three cycles on, return at next take
    task automatic run(input logic [2:0] op, input logic [3:0] sh, input logic ce, input logic [3:0] cs,
                       input logic [7:0] dv, input logic pe, input logic [5:0] sa, input logic [5:0] da,
                       input logic [23:0] src, input logic [23:0] dst);
        int w;
        w = 0;
        while (slot_start_o !== 1'h1 && w < 4)
        begin
            tick();
            w++;
        end
        i_mem.put(sa, src);
        i_mem.put(da, dst);
        opcode_i = spa_pkg::spa_op_t'(op);
        {shift_code_i, cond_en_i, cond_sel_i, digit_accumulator_register_i, prog_end_i} = {sh, ce, cs, dv, pe};
        src_addr_i = sa;
        dst_addr_i = da;
        instr_valid_i = 1'h1;
        tick();
        instr_valid_i = 1'h0;
        tick();
        tick();
        chk("write strobe", wr_en_o, 1'h1);
        chk("write place", wr_addr_o, da);
        tick();
    endtask

    initial
    begin
        repeat (20) @(posedge ref_clk_i);
        chk_rst();
        #1;
        resetn_i = 1'h1;
        // **********
        // period: idle slots still count, no write-back
        // **********
        n = 0;
        while (period_end_o !== 1'h1 && n < 800)
        begin
            tick();
            n++;
        end
        n = 0;
        k = 0;
        do
        begin
            tick();
            n++;
            k += (slot_start_o === 1'h1);
            if (wr_en_o !== 1'h0)
            begin
                chk("idle strobe", wr_en_o, 1'h0);
            end
        end
        while (period_end_o !== 1'h1 && n < 800);
        chk("period cycles", n, 768);
        chk("period slots", k, 192);
        foreach (rows[i])
        begin
            r = rows[i];
            run(r.op, r.sh, r.ce, r.cs, r.dv, 1'h0, 6'h32, 6'h07, r.src, r.dst);
            chk("row result", wr_data_o, r.res);
            chk("row carry", carry_o, r.cy);
            chk("row overflow", overflow_o, r.ov);
        end
        // **********
        // carry left set, then the arithmetic no-operation
        // **********
        run(3'h0, 4'h0, 1'h0, 4'h0, 8'h00, 1'h0, 6'h32, 6'h07, 24'h000001, 24'hFFFFFF);
        chk("carry set", carry_o, 1'h1);
        run(3'h4, 4'h0, 1'h0, 4'h0, 8'h00, 1'h0, 6'h00, 6'h00, 24'h000055, 24'h000055);
        chk("no-op carry", carry_o, 1'h0);
        chk("no-op keeps place", wr_data_o, 24'h000055);
        // **********
        // limiting off, wrap, on by xor, off, mid-run reset, on by end
        // **********
        run(3'h0, 4'h0, 1'h1, 4'h0, 8'h01, 1'h0, 6'h32, 6'h07, 24'h000000, 24'h000000);
        chk("limit off", limit_en_o, 1'h0);
        run(3'h2, 4'h0, 1'h0, 4'h0, 8'h00, 1'h0, 6'h32, 6'h07, 24'h7FFFFF, 24'h000001);
        chk("wrapped sum", wr_data_o, 24'h800000);
        chk("wrap overflow", overflow_o, 1'h1);
        run(3'h5, 4'h0, 1'h1, 4'h0, 8'h01, 1'h0, 6'h32, 6'h07, 24'h000000, 24'h000000);
        chk("limit on by xor", limit_en_o, 1'h1);
        run(3'h0, 4'h0, 1'h1, 4'h8, 8'h00, 1'h0, 6'h32, 6'h07, 24'h000000, 24'h000000);
        chk("limit off again", limit_en_o, 1'h0);
        // reset lands between edges so nothing races the clock
        resetn_i = 1'h0;
        #1;
        chk_rst();
        tick();
        resetn_i = 1'h1;
        run(3'h2, 4'h0, 1'h0, 4'h0, 8'h00, 1'h0, 6'h32, 6'h07, 24'h000010, 24'h000020);
        chk("first slot after reset", wr_data_o, 24'h000030);
        run(3'h0, 4'h0, 1'h1, 4'h8, 8'h00, 1'h0, 6'h32, 6'h07, 24'h000000, 24'h000000);
        run(3'h4, 4'h0, 1'h0, 4'h0, 8'h00, 1'h1, 6'h32, 6'h07, 24'h000005, 24'h000000);
        chk("limit on by end", limit_en_o, 1'h1);
        test_done();
    end
endmodule // spa_alu_slice_tb_top
